// [hdl/fpc_pkg.sv]
// Summary of operation
// RULE1 - registers load defaults only on power-on or hard reset, never soft reset
// RULE2 - floppy mode bit 0: 0 normal floppy mode, 1 second enhanced mode
// RULE3 - floppy mode bit 1: 0 burst DMA, 1 non-burst DMA (default)
// RULE4 - floppy mode bits 3:2: 11 AT (default), 01/00 alternates, 10 reserved
// RULE5 - floppy mode bit 6: 0 open-drain drive outputs, 1 push-pull
// RULE6 - floppy mode bit 7: 1 puts all floppy drive outputs in high impedance; only FLP_PIN_O/FLP_PIN_OE_N are released, DENSITY_PIN_O stays driven
// RULE7 - output type and tristate bits never touch floppy signals on port pins
// RULE8 - option bit 0 forces write protect active whenever either drive is selected
// RULE9 - forced write protect also covers a drive attached on the port pins
// RULE10 - option bits 3:2: 00/01 normal density, 10 forced 1, 11 forced 0
// RULE11 - type register: drive A bits 1:0, drive B 3:2, 7:4 spare; default FF
// RULE12 - reserved index after type register reads zero and ignores writes
// RULE13 - drive register: type bits 1:0, rate table 4:3; bits 2,5,7 read zero
// RULE14 - drive register bit 6 set disables write precompensation for that drive
// RULE15 - drive 1 register has the same layout and default as drive 0
// RULE16 - the boot floppy is always drive 0
// RULE17 - port mode bits 2:0 select printer, bidirectional, EPP, ECP combinations
// RULE18 - port mode bits 6:3 hold the ECP FIFO threshold, default 0111b
// RULE19 - port mode bit 7 set: interrupt pulses low then releases, not in 100/000
// RULE20 - interrupt type 0: follows acknowledge, level type in ECP-family modes
// RULE21 - routing bits 1:0: 00 normal, 01 drive 1 on port, 10 both on port
// RULE22 - routing bits 7:2 reserved, written zero; default zero
// RULE23 - reserved encodings of mode fields behave like the field's default
package fpc_pkg;

  // ****************************************
  // address map
  // ****************************************
  localparam logic [11:0] FPC_FDC_BASE = 12'h000;
  localparam logic [11:0] FPC_PP_BASE = 12'h400;
  localparam logic [11:0] FPC_STATUS_ADDR = 12'h800;
  localparam logic [7:0] FPC_IDX_MODE = 8'hF0;
  localparam logic [7:0] FPC_IDX_OPTION = 8'hF1;
  localparam logic [7:0] FPC_IDX_TYPE = 8'hF2;
  localparam logic [7:0] FPC_IDX_RSVD = 8'hF3;
  localparam logic [7:0] FPC_IDX_DRV0 = 8'hF4;
  localparam logic [7:0] FPC_IDX_DRV1 = 8'hF5;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] FPC_FDD_MODE_RST = 8'h0E;
  localparam logic [7:0] FPC_FDD_OPT_RST = 8'h00;
  localparam logic [7:0] FPC_FDD_TYPE_RST = 8'hFF;
  localparam logic [7:0] FPC_DRV_RST = 8'h00;
  localparam logic [7:0] FPC_PP_MODE_RST = 8'h3C;
  localparam logic [7:0] FPC_PP_ROUTE_RST = 8'h00;

  // ****************************************
  // field positions and masks
  // ****************************************
  localparam int FPC_MODE_ENH = 0;
  localparam int FPC_MODE_NONBURST = 1;
  localparam int FPC_MODE_IF_LSB = 2;
  localparam int FPC_MODE_PUSHPULL = 6;
  localparam int FPC_MODE_TRISTATE = 7;
  localparam int FPC_OPT_FWP = 0;
  localparam int FPC_OPT_DENS_LSB = 2;
  localparam int FPC_DRV_TYPE_LSB = 0;
  localparam int FPC_DRV_RATE_LSB = 3;
  localparam int FPC_DRV_PRECOMP_DIS = 6;
  localparam logic [7:0] FPC_DRV_RW_MASK = 8'h5B;
  localparam int FPC_PP_MODE_LSB = 0;
  localparam int FPC_PP_THR_LSB = 3;
  localparam int FPC_PP_ITYPE = 7;
  localparam int FPC_FLP_PINS = 8;
  localparam int FPC_SYNC_BITS = 3;

  // ****************************************
  // encodings
  // ****************************************
  typedef enum logic [1:0] {
    FPC_IF_ALT_B = 2'b00, FPC_IF_ALT_A = 2'b01, FPC_IF_RSVD = 2'b10, FPC_IF_AT = 2'b11
  } fpc_iface_t;

  typedef enum logic [2:0] {
    FPC_PP_SPP = 3'b000, FPC_PP_EPP19 = 3'b001, FPC_PP_ECP = 3'b010,
    FPC_PP_ECP_EPP19 = 3'b011, FPC_PP_PRINTER = 3'b100, FPC_PP_EPP17 = 3'b101,
    FPC_PP_RSVD = 3'b110, FPC_PP_ECP_EPP17 = 3'b111
  } fpc_pp_mode_t;

  typedef enum logic [3:0] {
    FPC_ST_IDLE = 4'b0001, FPC_ST_WRDATA = 4'b0010,
    FPC_ST_RDWAIT = 4'b0100, FPC_ST_RDDATA = 4'b1000
  } fpc_bus_state_t;

  // byte address of a register index inside a logical device bank
  function automatic logic [11:0] fpc_addr(input logic [11:0] base, input logic [7:0] idx);
    fpc_addr = base + {2'b00, idx, 2'b00};
  endfunction : fpc_addr

endpackage : fpc_pkg

// [hdl/fpc_regs.sv]
// The AHB-Lite register port was chosen for this implementation.
module fpc_regs
  import fpc_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // floppy core side
  input wire logic [FPC_FLP_PINS-1:0] FDC_PIN_VAL,
  input wire logic [1:0] FDC_DRV_SEL,
  input wire logic FDC_DENSITY,
  output logic FDC_WRTPRT_N,
  // dedicated floppy pins
  output logic [FPC_FLP_PINS-1:0] FLP_PIN_O,
  output logic [FPC_FLP_PINS-1:0] FLP_PIN_OE_N,
  output logic DENSITY_PIN_O,
  input wire logic WRTPRT_N_PIN,
  // floppy signals on parallel port pins
  output logic [FPC_FLP_PINS-1:0] PORT_FLP_O,
  output logic PORT_FLP_OE_N,
  input wire logic PORT_WRTPRT_N_PIN,
  // parallel port interrupt
  input wire logic PP_ACK_N_PIN,
  input wire logic PP_LEVEL_IRQ,
  output logic PP_IRQ_O,
  output logic PP_IRQ_OE_N,
  // decoded configuration
  output logic FDC_ENH_MODE,
  output logic FDC_BURST_EN,
  output logic [1:0] FDC_IFACE,
  output logic [1:0] DRV_TYPE,
  output logic [1:0] DRV_RATE_TBL,
  output logic PRECOMP_EN,
  output logic [2:0] PP_MODE,
  output logic [3:0] ECP_THRESHOLD,
  output logic [1:0] DRIVE_ON_PORT
);

  // ****************************************
  // declarations
  // ****************************************
  fpc_bus_state_t state_ff, nxt_state;
  logic [11:0] addr_ff;
  logic addr_ok_ff;
  logic [31:0] hrdata_ff;
  logic sel_xfer, wr_en;
  logic [7:0] rd_val;
  logic [7:0] fdd_mode_ff, fdd_opt_ff, fdd_type_ff, pp_mode_ff, pp_route_ff;
  logic [7:0] drv_ff [2];
  logic [FPC_SYNC_BITS-1:0] sync1_ff, sync2_ff;
  logic wp_flp_s, wp_port_s, ack_s;
  logic drv_idx, wp_src_n, irq_src, src_prev_ff, pulse_mode, src_rise;
  logic [2:0] pp_mode_eff;
  logic [1:0] on_port;
  logic ecp_family;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);

  // ****************************************
  // bus slave
  // ****************************************
  assign sel_xfer = HSEL & HTRANS[1] & HREADY;

  // reads get one wait state so a preceding write is always visible
  always_comb begin
    nxt_state = FPC_ST_IDLE;
    case (state_ff)
      FPC_ST_RDWAIT: nxt_state = FPC_ST_RDDATA;
      FPC_ST_IDLE, FPC_ST_WRDATA, FPC_ST_RDDATA: begin
        if (sel_xfer) begin
          nxt_state = HWRITE ? FPC_ST_WRDATA : FPC_ST_RDWAIT;
        end
      end
      default: nxt_state = FPC_ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_ff <= FPC_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // address phase capture; only aligned word accesses are mapped
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      addr_ff <= 12'h000;
      addr_ok_ff <= 1'b0;
    end else if (sel_xfer) begin
      addr_ff <= HADDR[11:0];
      addr_ok_ff <= (HADDR[31:12] == 20'h00000) && (HSIZE == 3'b010);
    end
  end

  assign wr_en = (state_ff == FPC_ST_WRDATA) && addr_ok_ff;
  assign HREADYOUT = (state_ff != FPC_ST_RDWAIT);
  assign HRESP = 1'b0;
  assign HRDATA = hrdata_ff;

  // read mux; unmapped words read zero
  always_comb begin
    rd_val = 8'h00;
    if (addr_ok_ff) begin
      case (addr_ff)
        fpc_addr(FPC_FDC_BASE, FPC_IDX_MODE): rd_val = fdd_mode_ff;
        fpc_addr(FPC_FDC_BASE, FPC_IDX_OPTION): rd_val = fdd_opt_ff;
        fpc_addr(FPC_FDC_BASE, FPC_IDX_TYPE): rd_val = fdd_type_ff;
        // RULE12 reserved reads zero
        fpc_addr(FPC_FDC_BASE, FPC_IDX_RSVD): rd_val = 8'h00;
        fpc_addr(FPC_FDC_BASE, FPC_IDX_DRV0): rd_val = drv_ff[0];
        fpc_addr(FPC_FDC_BASE, FPC_IDX_DRV1): rd_val = drv_ff[1];
        fpc_addr(FPC_PP_BASE, FPC_IDX_MODE): rd_val = pp_mode_ff;
        fpc_addr(FPC_PP_BASE, FPC_IDX_OPTION): rd_val = pp_route_ff;
        FPC_STATUS_ADDR: rd_val = {4'h0, drv_idx, DENSITY_PIN_O, FDC_WRTPRT_N, PORT_FLP_OE_N};
        default: rd_val = 8'h00;
      endcase
    end
  end

  // read data loaded during the wait state
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      hrdata_ff <= 32'h00000000;
    end else if (state_ff == FPC_ST_RDWAIT) begin
      hrdata_ff <= {24'h000000, rd_val};
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  // RULE1 hard reset only; a soft reset never reaches ARST_N
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      fdd_mode_ff <= FPC_FDD_MODE_RST;
      fdd_opt_ff <= FPC_FDD_OPT_RST;
      fdd_type_ff <= FPC_FDD_TYPE_RST;
      pp_mode_ff <= FPC_PP_MODE_RST;
      pp_route_ff <= FPC_PP_ROUTE_RST;
    end else if (wr_en) begin
      case (addr_ff)
        fpc_addr(FPC_FDC_BASE, FPC_IDX_MODE): fdd_mode_ff <= HWDATA[7:0];
        fpc_addr(FPC_FDC_BASE, FPC_IDX_OPTION): fdd_opt_ff <= HWDATA[7:0];
        // RULE11 spare bits stay writable
        fpc_addr(FPC_FDC_BASE, FPC_IDX_TYPE): fdd_type_ff <= HWDATA[7:0];
        fpc_addr(FPC_PP_BASE, FPC_IDX_MODE): pp_mode_ff <= HWDATA[7:0];
        // RULE22 reserved bits kept zero
        fpc_addr(FPC_PP_BASE, FPC_IDX_OPTION): pp_route_ff <= {6'h00, HWDATA[1:0]};
        default: pp_route_ff <= pp_route_ff;
      endcase
    end
  end

  // per-drive setup registers, identical for both drives
  for (genvar d = 0; d < 2; d++) begin : g_drv
    // RULE15 same layout and default
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        drv_ff[d] <= FPC_DRV_RST;
      end else if (wr_en && addr_ff == fpc_addr(FPC_FDC_BASE, FPC_IDX_DRV0 + 8'(d))) begin
        // RULE13 read-only bits masked
        drv_ff[d] <= HWDATA[7:0] & FPC_DRV_RW_MASK;
      end
    end
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  // second stage only is read, to keep metastability out of logic
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sync1_ff <= '1;
      sync2_ff <= '1;
    end else begin
      sync1_ff <= {PP_ACK_N_PIN, PORT_WRTPRT_N_PIN, WRTPRT_N_PIN};
      sync2_ff <= sync1_ff;
    end
  end

  assign wp_flp_s = sync2_ff[0];
  assign wp_port_s = sync2_ff[1];
  assign ack_s = sync2_ff[2];

  // ****************************************
  // floppy decode
  // ****************************************
  // RULE16 drive 0 unless drive 1 alone is selected
  assign drv_idx = FDC_DRV_SEL[1] & ~FDC_DRV_SEL[0];

  // RULE21 drive routing
  always_comb begin
    case (pp_route_ff[1:0])
      2'b01: on_port = 2'b10;
      2'b10: on_port = 2'b11;
      // RULE23 reserved acts as normal
      default: on_port = 2'b00;
    endcase
  end

  // RULE9 port-pin drive supplies its own protect input
  assign wp_src_n = on_port[drv_idx] ? wp_port_s : wp_flp_s;

  // registered floppy controls and core inputs
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      FDC_WRTPRT_N <= 1'b1;
      DENSITY_PIN_O <= 1'b0;
      FDC_ENH_MODE <= 1'b0;
      FDC_BURST_EN <= 1'b0;
      FDC_IFACE <= FPC_IF_AT;
      DRV_TYPE <= 2'b00;
      DRV_RATE_TBL <= 2'b00;
      PRECOMP_EN <= 1'b1;
      DRIVE_ON_PORT <= 2'b00;
    end else begin
      // RULE8 forced protect while a drive is selected
      FDC_WRTPRT_N <= wp_src_n & ~(fdd_opt_ff[FPC_OPT_FWP] & (|FDC_DRV_SEL));
      // RULE10 density forcing
      case (fdd_opt_ff[FPC_OPT_DENS_LSB +: 2])
        2'b10: DENSITY_PIN_O <= 1'b1;
        2'b11: DENSITY_PIN_O <= 1'b0;
        default: DENSITY_PIN_O <= FDC_DENSITY;
      endcase
      // RULE2 enhanced mode select
      FDC_ENH_MODE <= fdd_mode_ff[FPC_MODE_ENH];
      // RULE3 burst when bit clear
      FDC_BURST_EN <= ~fdd_mode_ff[FPC_MODE_NONBURST];
      // RULE4 interface style, reserved to AT
      if (fdd_mode_ff[FPC_MODE_IF_LSB +: 2] == FPC_IF_RSVD) begin
        FDC_IFACE <= FPC_IF_AT;
      end else begin
        FDC_IFACE <= fdd_mode_ff[FPC_MODE_IF_LSB +: 2];
      end
      DRV_TYPE <= drv_ff[drv_idx][FPC_DRV_TYPE_LSB +: 2];
      DRV_RATE_TBL <= drv_ff[drv_idx][FPC_DRV_RATE_LSB +: 2];
      // RULE14 precompensation disable
      PRECOMP_EN <= ~drv_ff[drv_idx][FPC_DRV_PRECOMP_DIS];
      DRIVE_ON_PORT <= on_port;
    end
  end

  // dedicated floppy pins, one driver per pin
  for (genvar p = 0; p < FPC_FLP_PINS; p++) begin : g_pin
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        FLP_PIN_O[p] <= 1'b0;
        FLP_PIN_OE_N[p] <= 1'b1;
      end else if (fdd_mode_ff[FPC_MODE_TRISTATE]) begin
        // RULE6 FLP_PIN_O/FLP_PIN_OE_N released, DENSITY_PIN_O stays driven
        FLP_PIN_O[p] <= 1'b0;
        FLP_PIN_OE_N[p] <= 1'b1;
      end else if (fdd_mode_ff[FPC_MODE_PUSHPULL]) begin
        // RULE5 push-pull drive
        FLP_PIN_O[p] <= FDC_PIN_VAL[p];
        FLP_PIN_OE_N[p] <= 1'b0;
      end else begin
        // RULE5 open drain pulls low only
        FLP_PIN_O[p] <= 1'b0;
        FLP_PIN_OE_N[p] <= FDC_PIN_VAL[p];
      end
    end
  end

  // RULE7 port pins ignore type and tristate bits
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PORT_FLP_O <= '0;
      PORT_FLP_OE_N <= 1'b1;
    end else begin
      PORT_FLP_O <= FDC_PIN_VAL;
      PORT_FLP_OE_N <= ~(|on_port);
    end
  end

  // ****************************************
  // parallel port decode and interrupt
  // ****************************************
  // RULE17 port mode, RULE23 reserved to printer
  assign pp_mode_eff = (pp_mode_ff[FPC_PP_MODE_LSB +: 3] == FPC_PP_RSVD) ?
                       FPC_PP_PRINTER : pp_mode_ff[FPC_PP_MODE_LSB +: 3];
  assign ecp_family = (pp_mode_eff == FPC_PP_ECP) || (pp_mode_eff == FPC_PP_ECP_EPP19) ||
                      (pp_mode_eff == FPC_PP_ECP_EPP17);
  // RULE20 level in ECP family, else follows acknowledge
  assign irq_src = ecp_family ? PP_LEVEL_IRQ : ack_s;
  // RULE19 pulse style invalid in printer and bidirectional
  assign pulse_mode = pp_mode_ff[FPC_PP_ITYPE] && (pp_mode_eff != FPC_PP_PRINTER) &&
                      (pp_mode_eff != FPC_PP_SPP);
  assign src_rise = irq_src & ~src_prev_ff;

  // decoded port configuration
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PP_MODE <= FPC_PP_PRINTER;
      ECP_THRESHOLD <= 4'h7;
    end else begin
      PP_MODE <= pp_mode_eff;
      // RULE18 fifo threshold
      ECP_THRESHOLD <= pp_mode_ff[FPC_PP_THR_LSB +: 4];
    end
  end

  // interrupt driver; pulse is one cycle low then high impedance
  // edge history resets high, the idle acknowledge level, so no false edge follows reset
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      src_prev_ff <= 1'b1;
      PP_IRQ_O <= 1'b0;
      PP_IRQ_OE_N <= 1'b1;
    end else begin
      src_prev_ff <= irq_src;
      if (pulse_mode) begin
        // RULE19 low pulse on each event
        PP_IRQ_O <= 1'b0;
        PP_IRQ_OE_N <= ~src_rise;
      end else begin
        PP_IRQ_O <= irq_src;
        PP_IRQ_OE_N <= 1'b0;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence s_req(logic wr, logic [11:0] a);
    sel_xfer && HWRITE == wr && HADDR == {20'h00000, a} && HSIZE == 3'b010;
  endsequence

  sequence s_irq_pulse;
    !PP_IRQ_OE_N && !PP_IRQ_O ##1 PP_IRQ_OE_N;
  endsequence

  AST_RSVD_ZERO: assert property ( // RULE12
    s_req(1'b0, fpc_addr(FPC_FDC_BASE, FPC_IDX_RSVD)) |-> ##1 !HREADYOUT ##1
    (HREADYOUT && HRDATA == 32'h00000000))
    else $error("reserved index read not zero");

  AST_MODE_WRITE: assert property ( // RULE2
    s_req(1'b1, fpc_addr(FPC_FDC_BASE, FPC_IDX_MODE)) ##1 HREADYOUT |=>
    fdd_mode_ff == $past(HWDATA[7:0]) ##1 FDC_ENH_MODE == $past(fdd_mode_ff[0]))
    else $error("floppy mode write not taken");

  AST_TRISTATE: assert property ( // RULE6
    fdd_mode_ff[FPC_MODE_TRISTATE] |=> (&FLP_PIN_OE_N))
    else $error("floppy pins not released");

  AST_PUSHPULL: assert property ( // RULE5
    !fdd_mode_ff[FPC_MODE_TRISTATE] && fdd_mode_ff[FPC_MODE_PUSHPULL] |=>
    FLP_PIN_OE_N == '0 && FLP_PIN_O == $past(FDC_PIN_VAL))
    else $error("push-pull drive wrong");

  AST_FORCED_WP: assert property ( // RULE8
    fdd_opt_ff[FPC_OPT_FWP] && (|FDC_DRV_SEL) |=> !FDC_WRTPRT_N)
    else $error("write protect not forced");

  AST_DENSITY_ZERO: assert property ( // RULE10
    fdd_opt_ff[3:2] == 2'b11 |=> !DENSITY_PIN_O)
    else $error("density not forced low");

  AST_DRV_ZERO_BITS: assert property ( // RULE13
    (drv_ff[0] & ~FPC_DRV_RW_MASK) == 8'h00 && (drv_ff[1] & ~FPC_DRV_RW_MASK) == 8'h00)
    else $error("read-only drive bits set");

  AST_PORT_KEEPS_DRIVE: assert property ( // RULE7
    pp_route_ff[1:0] == 2'b01 && fdd_mode_ff[FPC_MODE_TRISTATE] |=> !PORT_FLP_OE_N)
    else $error("port pins affected by tristate");

  AST_IRQ_PULSE: assert property ( // RULE19
    pulse_mode && src_rise ##1 pulse_mode && !src_rise |-> s_irq_pulse)
    else $error("interrupt pulse shape wrong");

  AST_ROUTE_BOTH: assert property ( // RULE21
    pp_route_ff[1:0] == 2'b10 |=> DRIVE_ON_PORT == 2'b11)
    else $error("both drives not routed to port");

endmodule : fpc_regs

// [testbench/tb_top.sv]
module tb_top
  import fpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // signals
  // ****************************************
  typedef struct packed {logic [31:0] a; logic [7:0] w; logic [31:0] r;} fpc_row_t;
  logic SYS_CLK = 1'h0;
  logic ARST_N = 1'h0;
  logic HSEL = 1'h0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'h0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA;
  logic HREADYOUT, HRESP;
  logic [7:0] FDC_PIN_VAL = 8'hA5;
  logic [1:0] FDC_DRV_SEL = 2'h1;
  logic FDC_DENSITY = 1'h1;
  logic WRTPRT_N_PIN = 1'h1;
  logic PORT_WRTPRT_N_PIN = 1'h1;
  logic PP_ACK_N_PIN = 1'h1;
  logic PP_LEVEL_IRQ = 1'h0;
  logic FDC_WRTPRT_N, DENSITY_PIN_O, PORT_FLP_OE_N, PP_IRQ_O, PP_IRQ_OE_N;
  logic [7:0] FLP_PIN_O, FLP_PIN_OE_N, PORT_FLP_O;
  logic FDC_ENH_MODE, FDC_BURST_EN, PRECOMP_EN;
  logic [1:0] FDC_IFACE, DRV_TYPE, DRV_RATE_TBL, DRIVE_ON_PORT;
  logic [2:0] PP_MODE;
  logic [3:0] ECP_THRESHOLD;
  fpc_row_t rows [9];
  int bad_count = 0;
  int samples_checked = 0;

  // free-running system clock
  always #5 SYS_CLK = ~SYS_CLK;

  // hready loops back from the only slave
  fpc_regs fpc_regs_inst (
    .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .FDC_PIN_VAL(FDC_PIN_VAL),
    .FDC_DRV_SEL(FDC_DRV_SEL), .FDC_DENSITY(FDC_DENSITY), .FDC_WRTPRT_N(FDC_WRTPRT_N),
    .FLP_PIN_O(FLP_PIN_O), .FLP_PIN_OE_N(FLP_PIN_OE_N), .DENSITY_PIN_O(DENSITY_PIN_O),
    .WRTPRT_N_PIN(WRTPRT_N_PIN), .PORT_FLP_O(PORT_FLP_O), .PORT_FLP_OE_N(PORT_FLP_OE_N),
    .PORT_WRTPRT_N_PIN(PORT_WRTPRT_N_PIN), .PP_ACK_N_PIN(PP_ACK_N_PIN),
    .PP_LEVEL_IRQ(PP_LEVEL_IRQ), .PP_IRQ_O(PP_IRQ_O), .PP_IRQ_OE_N(PP_IRQ_OE_N),
    .FDC_ENH_MODE(FDC_ENH_MODE), .FDC_BURST_EN(FDC_BURST_EN), .FDC_IFACE(FDC_IFACE),
    .DRV_TYPE(DRV_TYPE), .DRV_RATE_TBL(DRV_RATE_TBL), .PRECOMP_EN(PRECOMP_EN),
    .PP_MODE(PP_MODE), .ECP_THRESHOLD(ECP_THRESHOLD), .DRIVE_ON_PORT(DRIVE_ON_PORT)
  );

  // ****************************************
  // helpers
  // ****************************************
  // byte address of a register index, own arithmetic
  function automatic logic [31:0] ra(input logic [11:0] base, input logic [7:0] idx);
    ra = {20'h0, base + {2'h0, idx, 2'h0}};
  endfunction : ra

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // one single transfer; a dead slave is caught by the watchdog
  task automatic bus(input logic [31:0] a, input logic wr, input logic [7:0] wd,
                     input logic [2:0] sz, output logic [31:0] rd);
    int n;
    n = 0;
    HSEL <= 1'h1;
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= wr;
    HSIZE <= sz;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (HREADYOUT !== 1'h1);
    HSEL <= 1'h0;
    HTRANS <= 2'h0;
    HWDATA <= {24'h0, wd};
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (HREADYOUT !== 1'h1);
    rd = HRDATA;
    check("bus response", {31'h0, HRESP}, 32'h0);
    // writes answer at once, reads after one wait state
    check("bus wait", 32'(n), wr ? 32'h2 : 32'h3);
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] junk;
    bus(a, 1'h1, d, 3'h2, junk);
  endtask : wr

  task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(a, 1'h0, 8'h0, 3'h2, v);
    check(name, v, exp);
  endtask : rd_chk

  // registered outputs need a few edges, synced pins need three
  task automatic settle();
    repeat (5) @(posedge SYS_CLK);
  endtask : settle

  task automatic do_reset();
    ARST_N <= 1'h0;
    repeat (5) @(posedge SYS_CLK);
    ARST_N <= 1'h1;
    @(posedge SYS_CLK);
  endtask : do_reset

  task automatic check_defaults();
    rd_chk("fdd mode", ra(FPC_FDC_BASE, FPC_IDX_MODE), 32'h0E);
    rd_chk("fdd option", ra(FPC_FDC_BASE, FPC_IDX_OPTION), 32'h00);
    rd_chk("fdd types", ra(FPC_FDC_BASE, FPC_IDX_TYPE), 32'hFF);
    rd_chk("reserved", ra(FPC_FDC_BASE, FPC_IDX_RSVD), 32'h00);
    rd_chk("drive0", ra(FPC_FDC_BASE, FPC_IDX_DRV0), 32'h00);
    rd_chk("drive1", ra(FPC_FDC_BASE, FPC_IDX_DRV1), 32'h00);
    rd_chk("pp mode", ra(FPC_PP_BASE, FPC_IDX_MODE), 32'h3C);
    rd_chk("pp route", ra(FPC_PP_BASE, FPC_IDX_OPTION), 32'h00);
    check("iface", FDC_IFACE, 32'h3);
    check("burst", FDC_BURST_EN, 32'h0);
    check("thresh", ECP_THRESHOLD, 32'h7);
  endtask : check_defaults

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    bad_count++;
    print_verdict();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    logic [31:0] junk;
    int cnt;
    do_reset();
    check_defaults();
    rows = '{'{ra(FPC_FDC_BASE, FPC_IDX_MODE), 8'hC3, 32'hC3},
             '{ra(FPC_FDC_BASE, FPC_IDX_OPTION), 8'h0D, 32'h0D},
             '{ra(FPC_FDC_BASE, FPC_IDX_TYPE), 8'hA5, 32'hA5},
             '{ra(FPC_FDC_BASE, FPC_IDX_RSVD), 8'hFF, 32'h00},
             '{ra(FPC_FDC_BASE, FPC_IDX_DRV0), 8'hFF, 32'h5B},
             '{ra(FPC_FDC_BASE, FPC_IDX_DRV1), 8'h08, 32'h08},
             '{ra(FPC_PP_BASE, FPC_IDX_MODE), 8'h95, 32'h95},
             '{ra(FPC_PP_BASE, FPC_IDX_OPTION), 8'h01, 32'h01},
             '{32'h900, 8'hFF, 32'h00}};
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd_chk("readback", rows[i].a, rows[i].r);
    end
    settle();
    check("enh", FDC_ENH_MODE, 32'h1);
    check("burst", FDC_BURST_EN, 32'h0);
    check("iface", FDC_IFACE, 32'h0);
    check("pin oe", FLP_PIN_OE_N, 32'hFF);
    check("port oe", PORT_FLP_OE_N, 32'h0);
    check("port pins", PORT_FLP_O, 32'hA5);
    check("density", DENSITY_PIN_O, 32'h0);
    check("wp forced", FDC_WRTPRT_N, 32'h0);
    check("type0", DRV_TYPE, 32'h3);
    check("rate0", DRV_RATE_TBL, 32'h3);
    check("precomp0", PRECOMP_EN, 32'h0);
    check("pp mode", PP_MODE, 32'h5);
    check("thresh", ECP_THRESHOLD, 32'h2);
    check("route", DRIVE_ON_PORT, 32'h2);
    FDC_DRV_SEL <= 2'h2;
    settle();
    // second drive uses its own register
    check("type1", DRV_TYPE, 32'h0);
    check("rate1", DRV_RATE_TBL, 32'h1);
    check("precomp1", PRECOMP_EN, 32'h1);
    wr(ra(FPC_FDC_BASE, FPC_IDX_MODE), 8'h44);
    settle();
    check("burst on", FDC_BURST_EN, 32'h1);
    check("iface alt", FDC_IFACE, 32'h1);
    check("pp out", FLP_PIN_O, 32'hA5);
    check("pp oe", FLP_PIN_OE_N, 32'h00);
    wr(ra(FPC_FDC_BASE, FPC_IDX_MODE), 8'h00);
    settle();
    check("od out", FLP_PIN_O, 32'h00);
    check("od oe", FLP_PIN_OE_N, 32'hA5);
    wr(ra(FPC_FDC_BASE, FPC_IDX_MODE), 8'h08);
    wr(ra(FPC_PP_BASE, FPC_IDX_MODE), 8'h36);
    wr(ra(FPC_PP_BASE, FPC_IDX_OPTION), 8'h03);
    settle();
    check("iface rsvd", FDC_IFACE, 32'h3);
    check("pp rsvd", PP_MODE, 32'h4);
    check("thresh rsvd", ECP_THRESHOLD, 32'h6);
    check("route rsvd", DRIVE_ON_PORT, 32'h0);
    wr(ra(FPC_PP_BASE, FPC_IDX_OPTION), 8'h02);
    wr(ra(FPC_FDC_BASE, FPC_IDX_OPTION), 8'h00);
    PORT_WRTPRT_N_PIN <= 1'h0;
    settle();
    check("both on port", DRIVE_ON_PORT, 32'h3);
    check("wp port low", FDC_WRTPRT_N, 32'h0);
    PORT_WRTPRT_N_PIN <= 1'h1;
    settle();
    check("wp port high", FDC_WRTPRT_N, 32'h1);
    wr(ra(FPC_FDC_BASE, FPC_IDX_OPTION), 8'h01);
    settle();
    check("wp forced port", FDC_WRTPRT_N, 32'h0);
    FDC_DRV_SEL <= 2'h0;
    settle();
    check("wp unselected", FDC_WRTPRT_N, 32'h1);
    FDC_DENSITY <= 1'h0;
    wr(ra(FPC_FDC_BASE, FPC_IDX_OPTION), 8'h08);
    settle();
    check("dens one", DENSITY_PIN_O, 32'h1);
    wr(ra(FPC_FDC_BASE, FPC_IDX_OPTION), 8'h04);
    settle();
    check("dens follow0", DENSITY_PIN_O, 32'h0);
    FDC_DENSITY <= 1'h1;
    settle();
    check("dens follow1", DENSITY_PIN_O, 32'h1);
    // narrow transfers are refused, register keeps its value
    bus(ra(FPC_FDC_BASE, FPC_IDX_TYPE), 1'h1, 8'h00, 3'h0, junk);
    rd_chk("narrow write", ra(FPC_FDC_BASE, FPC_IDX_TYPE), 32'hA5);
    wr(ra(FPC_PP_BASE, FPC_IDX_MODE), 8'h87);
    settle();
    check("pp mode e17", PP_MODE, 32'h7);
    check("irq released", PP_IRQ_OE_N, 32'h1);
    PP_LEVEL_IRQ <= 1'h1;
    cnt = 0;
    repeat (8) begin
      @(negedge SYS_CLK);
      if (PP_IRQ_OE_N === 1'h0) cnt++;
    end
    @(posedge SYS_CLK);
    check("pulse width", 32'(cnt), 32'h1);
    wr(ra(FPC_PP_BASE, FPC_IDX_MODE), 8'h03);
    settle();
    check("pp mode e19", PP_MODE, 32'h3);
    check("level oe", PP_IRQ_OE_N, 32'h0);
    check("level hi", PP_IRQ_O, 32'h1);
    PP_LEVEL_IRQ <= 1'h0;
    settle();
    check("level lo", PP_IRQ_O, 32'h0);
    wr(ra(FPC_PP_BASE, FPC_IDX_MODE), 8'h84);
    PP_ACK_N_PIN <= 1'h0;
    settle();
    check("ack oe", PP_IRQ_OE_N, 32'h0);
    check("ack lo", PP_IRQ_O, 32'h0);
    PP_ACK_N_PIN <= 1'h1;
    settle();
    check("ack hi", PP_IRQ_O, 32'h1);
    // hard reset in mid-run restores defaults
    do_reset();
    check_defaults();
    print_verdict();
  end

endmodule : tb_top
